/* src/sil_top.sv */
/*
 Injection symbol registers, symbol pair injector and receive line state register.
 Assumes one pair per 80 ns slot, rx pairs on sys_clk, signal detect from a pin.
*/
`timescale 1ns/1ps
`default_nettype none
module sil_top (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [7:0] cb_addr,
   input wire logic cb_wr,
   input wire logic cb_rd,
   input wire logic [7:0] cb_wdata,
   output logic [7:0] cb_rdata,
   output logic cb_write_reject,
   input wire logic [1:0] inj_mode,
   input wire logic [7:0] injection_threshold,
   output logic inj_one_shot_done,
   input wire logic tx_in_valid,
   output logic tx_in_ready,
   input wire logic [9:0] tx_in_pair,
   input wire logic tx_in_jk,
   input wire logic tx_in_data,
   output logic tx_out_valid,
   input wire logic tx_out_ready,
   output logic [9:0] tx_out_pair,
   input wire logic rx_valid,
   input wire logic [9:0] rx_pair,
   input wire logic signal_detect
);
   ////////////////////////////////////////////////////////////////
   logic [4:0] first_injection_symbol, second_injection_symbol;
   logic [4:0] next_first, next_second;
   logic [2:0] resv_first, resv_second, next_resv_first, next_resv_second;
   logic [2:0] line_code, next_line_code;
   logic line_state_unknown_flag, next_lsu;
   logic [7:0] next_rdata;
   logic next_reject;
   logic [9:0] inj_value;

   assign inj_value = {second_injection_symbol, first_injection_symbol};

   always_comb
   begin
      next_first = first_injection_symbol;
      next_second = second_injection_symbol;
      next_resv_first = resv_first;
      next_resv_second = resv_second;
      next_reject = 1'b0;
      next_rdata = cb_rdata;
      if (cb_wr && cb_addr == sil_pkg::ADDR_FIRST)
      begin
         next_first = cb_wdata[4:0];
         next_resv_first = cb_wdata[7:5];
      end
      if (cb_wr && cb_addr == sil_pkg::ADDR_SECOND)
      begin
         next_second = cb_wdata[4:0];
         next_resv_second = cb_wdata[7:5];
      end
      // line state is never written, only flagged
      if (cb_wr && cb_addr == sil_pkg::ADDR_LINE)
         next_reject = 1'b1;
      if (cb_rd)
      begin
         case (cb_addr)
            sil_pkg::ADDR_FIRST: next_rdata = {resv_first, first_injection_symbol};
            sil_pkg::ADDR_SECOND: next_rdata = {resv_second, second_injection_symbol};
            sil_pkg::ADDR_LINE: next_rdata = {4'h0, line_state_unknown_flag, line_code};
            default: next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         first_injection_symbol <= 5'h00;
         second_injection_symbol <= 5'h00;
         resv_first <= sil_pkg::RESV_RESET;
         resv_second <= sil_pkg::RESV_RESET;
         cb_rdata <= 8'h00;
         cb_write_reject <= 1'b0;
      end
      else
      begin
         first_injection_symbol <= next_first;
         second_injection_symbol <= next_second;
         resv_first <= next_resv_first;
         resv_second <= next_resv_second;
         cb_rdata <= next_rdata;
         cb_write_reject <= next_reject;
      end
   end

   ////////////////////////////////////////////////////////////////
   // transmit: one pair accepted per 80 ns slot
   sil_pair_if #(.W(sil_pkg::PAIR_W)) push_p ();
   sil_pkg::sil_inj_e inj_state, next_inj_state;
   logic [7:0] inj_cnt, next_inj_cnt;
   logic [2:0] slot, next_slot;
   logic accept, hit, next_done;

   assign tx_in_ready = (slot == 3'h0) && push_p.ready;
   assign accept = tx_in_valid && tx_in_ready;
   assign push_p.valid = accept;
   assign push_p.data = hit ? inj_value : tx_in_pair;

   always_comb
   begin
      next_slot = (slot == sil_pkg::SLOT_LAST) ? 3'h0 : slot + 3'h1;
      next_inj_state = inj_state;
      next_inj_cnt = inj_cnt;
      next_done = 1'b0;
      hit = 1'b0;
      case (inj_state)
         sil_pkg::INJ_OFF:
         begin
            if (inj_mode == sil_pkg::MODE_ONESHOT)
               next_inj_state = sil_pkg::INJ_ARMED;
            if (accept && tx_in_data && inj_mode == sil_pkg::MODE_CONT)
               hit = 1'b1;
            if (accept && tx_in_data && inj_mode == sil_pkg::MODE_PERIODIC)
            begin
               if (inj_cnt == 8'h00)
               begin
                  hit = 1'b1;
                  next_inj_cnt = injection_threshold;
               end
               else
                  next_inj_cnt = inj_cnt - 8'h01;
            end
         end
         sil_pkg::INJ_ARMED:
         begin
            if (accept && tx_in_jk)
            begin
               if (injection_threshold == 8'h00)
               begin
                  hit = 1'b1;
                  next_done = 1'b1;
                  next_inj_state = sil_pkg::INJ_SPENT;
               end
               else
               begin
                  next_inj_cnt = injection_threshold;
                  next_inj_state = sil_pkg::INJ_COUNT;
               end
            end
         end
         sil_pkg::INJ_COUNT:
         begin
            if (accept)
            begin
               if (inj_cnt == 8'h01 && tx_in_data)
               begin
                  hit = 1'b1;
                  next_done = 1'b1;
                  next_inj_cnt = 8'h00;
                  next_inj_state = sil_pkg::INJ_SPENT;
               end
               else if (inj_cnt != 8'h01)
                  next_inj_cnt = inj_cnt - 8'h01;
            end
         end
         sil_pkg::INJ_SPENT:
         begin
            // waits for the mode to leave one-shot before re-arming
            if (inj_mode != sil_pkg::MODE_ONESHOT)
               next_inj_state = sil_pkg::INJ_OFF;
         end
         default: next_inj_state = sil_pkg::INJ_OFF;
      endcase
      if (inj_mode != sil_pkg::MODE_ONESHOT && inj_state != sil_pkg::INJ_OFF)
         next_inj_state = sil_pkg::INJ_OFF;
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         inj_state <= sil_pkg::INJ_OFF;
         inj_cnt <= 8'h00;
         slot <= 3'h0;
         inj_one_shot_done <= 1'b0;
      end
      else
      begin
         inj_state <= next_inj_state;
         inj_cnt <= next_inj_cnt;
         slot <= next_slot;
         inj_one_shot_done <= next_done;
      end
   end

   sil_buf #(.W(sil_pkg::PAIR_W)) u_buf (
      .sys_clk(sys_clk),
      .rst(rst),
      .in_p(push_p),
      .out_valid(tx_out_valid),
      .out_ready(tx_out_ready),
      .out_data(tx_out_pair)
   );

   ////////////////////////////////////////////////////////////////
   // receive line state
   logic [2:0] sd_sync;
   logic sd_ok, next_sd_ok;
   logic [2:0] run_kind, next_run_kind, kind;
   logic [4:0] run_cnt, next_run_cnt, noise_cnt, next_noise_cnt;
   logic [4:0] sym_a, sym_b;

   assign sym_a = rx_pair[4:0];
   assign sym_b = rx_pair[9:5];
   assign next_sd_ok = (sd_sync[1] == sd_sync[2]) ? sd_sync[2] : sd_ok;

   always_comb
   begin
      kind = sil_pkg::LS_NOISE;
      if (sym_a == sil_pkg::SYM_J && sym_b == sil_pkg::SYM_K)
         kind = sil_pkg::LS_ACTIVE;
      else if (sym_a == sil_pkg::SYM_I && sym_b == sil_pkg::SYM_I)
         kind = sil_pkg::LS_IDLE;
      else if (sym_a == sil_pkg::SYM_H && sym_b == sil_pkg::SYM_Q)
         kind = sil_pkg::LS_MASTER;
      else if (sym_a == sil_pkg::SYM_H && sym_b == sil_pkg::SYM_H)
         kind = sil_pkg::LS_HALT;
      else if (sym_a == sil_pkg::SYM_Q && sym_b == sil_pkg::SYM_Q)
         kind = sil_pkg::LS_QUIET;
      next_line_code = line_code;
      next_lsu = line_state_unknown_flag;
      next_run_kind = run_kind;
      next_run_cnt = run_cnt;
      next_noise_cnt = noise_cnt;
      if (!sd_ok)
      begin
         next_line_code = sil_pkg::LS_NOSIG;
         next_lsu = 1'b0;
         next_run_cnt = 5'h00;
         next_noise_cnt = 5'h00;
      end
      else if (rx_valid)
      begin
         next_run_kind = kind;
         next_run_cnt = (kind == run_kind && run_cnt != 5'h1F) ? run_cnt + 5'h01 : 5'h01;
         // data after JK is not noise while active
         if (kind == sil_pkg::LS_NOISE && (line_code != sil_pkg::LS_ACTIVE || line_state_unknown_flag))
            next_noise_cnt = noise_cnt + 5'h01;
         if (kind != line_code && line_code != sil_pkg::LS_ACTIVE
             && kind != sil_pkg::LS_NOISE)
            next_lsu = 1'b1;
         if (kind == sil_pkg::LS_ACTIVE
             || (kind == sil_pkg::LS_IDLE && next_run_cnt >= sil_pkg::RUN_IDLE)
             || (kind != sil_pkg::LS_NOISE && kind != sil_pkg::LS_IDLE
                 && next_run_cnt >= sil_pkg::RUN_REPEAT)
             || (kind == sil_pkg::LS_NOISE && next_noise_cnt >= sil_pkg::NOISE_EVENTS))
         begin
            next_line_code = kind;
            next_lsu = 1'b0;
            next_noise_cnt = 5'h00;
         end
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         sd_sync <= 3'h0;
         sd_ok <= 1'b0;
         line_code <= sil_pkg::LS_ACTIVE;
         line_state_unknown_flag <= 1'b1;
         run_kind <= sil_pkg::LS_NOISE;
         run_cnt <= 5'h00;
         noise_cnt <= 5'h00;
      end
      else
      begin
         sd_sync <= {sd_sync[1:0], signal_detect};
         sd_ok <= next_sd_ok;
         line_code <= next_line_code;
         line_state_unknown_flag <= next_lsu;
         run_kind <= next_run_kind;
         run_cnt <= next_run_cnt;
         noise_cnt <= next_noise_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////
   default clocking cb_clk @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence first_wr_s;
      cb_wr && cb_addr == sil_pkg::ADDR_FIRST;
   endsequence
   sequence line_wr_s;
      cb_wr && cb_addr == sil_pkg::ADDR_LINE;
   endsequence

   reset_lsu_a: assert property (@(posedge sys_clk) disable iff (1'b0) rst |=> line_state_unknown_flag)
      else $error("unknown flag not set by reset");
   resv_reset_a: assert property (@(posedge sys_clk) disable iff (1'b0) rst |=> resv_first == 3'h7 && resv_second == 3'h7)
      else $error("reserved bits not one after reset");
   first_write_a: assert property (first_wr_s ##1 cb_rd && cb_addr == sil_pkg::ADDR_FIRST |=> cb_rdata == {$past(cb_wdata, 2)})
      else $error("first symbol readback wrong");
   second_write_a: assert property (cb_wr && cb_addr == sil_pkg::ADDR_SECOND |=> second_injection_symbol == $past(cb_wdata[4:0]))
      else $error("second symbol not stored");
   // a second write in the pulse cycle may keep the pulse up
   line_reject_a: assert property (line_wr_s |=> cb_write_reject && $stable(line_code) ##0 (line_wr_s or (1'b1 ##1 !cb_write_reject)))
      else $error("line state write not rejected");
   cont_inject_a: assert property (accept && tx_in_data && inj_mode == sil_pkg::MODE_CONT && inj_state == sil_pkg::INJ_OFF |-> push_p.data == {second_injection_symbol, first_injection_symbol})
      else $error("continuous pair not injected");
   period_reload_a: assert property (accept && tx_in_data && inj_mode == sil_pkg::MODE_PERIODIC && inj_state == sil_pkg::INJ_OFF && inj_cnt == 8'h00 |=> inj_cnt == $past(injection_threshold))
      else $error("periodic counter not reloaded");
   count_step_a: assert property (inj_state == sil_pkg::INJ_COUNT && inj_mode == sil_pkg::MODE_ONESHOT && accept && inj_cnt > 8'h01 |=> inj_cnt == $past(inj_cnt) - 8'h01)
      else $error("injection counter did not step");
   oneshot_zero_a: assert property (inj_state == sil_pkg::INJ_ARMED && inj_mode == sil_pkg::MODE_ONESHOT && accept && tx_in_jk && injection_threshold == 8'h00 |=> inj_one_shot_done ##1 !inj_one_shot_done)
      else $error("one-shot with zero threshold missed");
   jk_active_a: assert property (sd_ok && rx_valid && kind == sil_pkg::LS_ACTIVE |=> line_code == sil_pkg::LS_ACTIVE && !line_state_unknown_flag)
      else $error("JK did not enter active state");
   slot_pace_a: assert property (accept |=> !tx_in_ready [*7])
      else $error("pairs accepted faster than one per slot");
endmodule
`default_nettype wire

/* src/sil_pkg.sv */
/*
 Constants for the symbol injection and line state register block.
 Assumes a 100 MHz sys_clk and an 8-bit control bus.
*/
package sil_pkg;
   localparam logic [7:0] ADDR_FIRST = 8'h06;
   localparam logic [7:0] ADDR_SECOND = 8'h07;
   localparam logic [7:0] ADDR_LINE = 8'h08;
   localparam int SYM_W = 5;
   localparam int PAIR_W = 10;
   localparam logic [2:0] RESV_RESET = 3'h7;
   localparam logic [4:0] SYM_J = 5'h18;
   localparam logic [4:0] SYM_K = 5'h11;
   localparam logic [4:0] SYM_I = 5'h1F;
   localparam logic [4:0] SYM_H = 5'h04;
   localparam logic [4:0] SYM_Q = 5'h00;
   // line state codes
   localparam logic [2:0] LS_ACTIVE = 3'h0;
   localparam logic [2:0] LS_IDLE = 3'h1;
   localparam logic [2:0] LS_NOSIG = 3'h2;
   localparam logic [2:0] LS_MASTER = 3'h4;
   localparam logic [2:0] LS_HALT = 3'h5;
   localparam logic [2:0] LS_QUIET = 3'h6;
   localparam logic [2:0] LS_NOISE = 3'h7;
   localparam logic [4:0] RUN_IDLE = 5'h02;
   localparam logic [4:0] RUN_REPEAT = 5'h08;
   localparam logic [4:0] NOISE_EVENTS = 5'h10;
   // injection modes
   localparam logic [1:0] MODE_NONE = 2'h0;
   localparam logic [1:0] MODE_ONESHOT = 2'h1;
   localparam logic [1:0] MODE_PERIODIC = 2'h2;
   localparam logic [1:0] MODE_CONT = 2'h3;
   localparam int CLK_PERIOD_NS = 10;
   localparam int PAIR_TIME_NS = 80;
   localparam int PAIR_CYCLES = PAIR_TIME_NS / CLK_PERIOD_NS;
   localparam logic [2:0] SLOT_LAST = 3'(PAIR_CYCLES - 1);
   typedef enum logic [3:0] {
      INJ_OFF = 4'h1,
      INJ_ARMED = 4'h2,
      INJ_COUNT = 4'h4,
      INJ_SPENT = 4'h8
   } sil_inj_e;
endpackage

/* src/sil_pair_if.sv */
/*
 Valid/ready carrier for symbol pairs between the injector and its buffer.
 Assumes both ends on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
interface sil_pair_if #(parameter int W = 10);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* src/sil_buf.sv */
/*
 Two-entry pair buffer; head entry drives the output from a flip-flop.
 Assumes the sink may stall at any time; nothing is dropped.
*/
`timescale 1ns/1ps
`default_nettype none
module sil_buf #(
   parameter int W = 10
) (
   input wire logic sys_clk,
   input wire logic rst,
   sil_pair_if.snk in_p,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   logic [W-1:0] head, tail, next_head, next_tail;
   logic [1:0] fill, next_fill;
   logic push, pop;

   assign in_p.ready = (fill != 2'h2);
   assign out_valid = (fill != 2'h0);
   assign out_data = head;
   assign push = in_p.valid && in_p.ready;
   assign pop = out_valid && out_ready;

   always_comb
   begin
      next_head = head;
      next_tail = tail;
      next_fill = fill;
      if (pop)
      begin
         next_head = tail;
      end
      if (push)
      begin
         if (fill == 2'h0 || (fill == 2'h1 && pop))
            next_head = in_p.data;
         else
            next_tail = in_p.data;
      end
      if (push && !pop)
         next_fill = fill + 2'h1;
      else if (pop && !push)
         next_fill = fill - 2'h1;
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         head <= '0;
         tail <= '0;
         fill <= 2'h0;
      end
      else
      begin
         head <= next_head;
         tail <= next_tail;
         fill <= next_fill;
      end
   end
endmodule
`default_nettype wire

/* test/sil_top_tb.sv */
/*
 Self-checking bench for sil_top: control bus registers, line state, injection and buffer.
 Assumes sil_pkg constants, a 100 MHz sys_clk and the bench as the only driver.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin failures++; \
   $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end
module sil_top_tb;
   localparam logic [9:0] JK = {sil_pkg::SYM_K, sil_pkg::SYM_J};
   localparam logic [9:0] INJ = {5'h0A, 5'h15};
   logic sys_clk, rst, cb_wr, cb_rd, cb_write_reject, inj_one_shot_done;
   logic [7:0] cb_addr, cb_wdata, cb_rdata, injection_threshold, v, keep;
   logic [1:0] inj_mode;
   logic tx_in_valid, tx_in_ready, tx_in_jk, tx_in_data, tx_out_valid, tx_out_ready;
   logic [9:0] tx_in_pair, tx_out_pair, rx_pair;
   logic rx_valid, signal_detect;
   logic [9:0] outq[$];
   logic [9:0] expq[$];
   int failures = 0;
   int num_checks = 0;
   int done_cnt = 0;
   int k;

   sil_top sil_top_i (.sys_clk(sys_clk), .rst(rst), .cb_addr(cb_addr), .cb_wr(cb_wr),
      .cb_rd(cb_rd), .cb_wdata(cb_wdata), .cb_rdata(cb_rdata),
      .cb_write_reject(cb_write_reject), .inj_mode(inj_mode),
      .injection_threshold(injection_threshold), .inj_one_shot_done(inj_one_shot_done),
      .tx_in_valid(tx_in_valid), .tx_in_ready(tx_in_ready), .tx_in_pair(tx_in_pair),
      .tx_in_jk(tx_in_jk), .tx_in_data(tx_in_data), .tx_out_valid(tx_out_valid),
      .tx_out_ready(tx_out_ready), .tx_out_pair(tx_out_pair), .rx_valid(rx_valid),
      .rx_pair(rx_pair), .signal_detect(signal_detect));

   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // output pairs taken only on a real handshake, so a stall shows as a gap
   always @(posedge sys_clk)
   begin
      if (!rst && tx_out_valid === 1'b1 && tx_out_ready === 1'b1)
         outq.push_back(tx_out_pair);
      if (!rst && inj_one_shot_done === 1'b1)
         done_cnt++;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic reset_dut(input int n);
      rst <= 1'b1;
      repeat (n) @(posedge sys_clk);
      rst <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      cb_wr <= 1'b1;
      cb_addr <= a;
      cb_wdata <= d;
      @(posedge sys_clk);
      cb_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      cb_rd <= 1'b1;
      cb_addr <= a;
      @(posedge sys_clk);
      cb_rd <= 1'b0;
      @(posedge sys_clk);
      d = cb_rdata;
   endtask

   task automatic setsym();
      wr(sil_pkg::ADDR_FIRST, 8'hF5);
      wr(sil_pkg::ADDR_SECOND, 8'hEA);
   endtask

   task automatic rx_chk(input logic [9:0] p, input int n, input logic [7:0] e);
      repeat (n)
      begin
         @(posedge sys_clk);
         rx_valid <= 1'b1;
         rx_pair <= p;
      end
      @(posedge sys_clk);
      rx_valid <= 1'b0;
      rd(sil_pkg::ADDR_LINE, v);
      `CHK("line state", e, v)
   endtask

   // hold valid until ready is seen at an edge, then release on that edge
   task automatic acc();
      k = 0;
      @(posedge sys_clk);
      while (tx_in_ready !== 1'b1 && k < 40)
      begin
         @(posedge sys_clk);
         k++;
      end
      `CHK("tx accepted", 1'b1, tx_in_ready)
      tx_in_valid <= 1'b0;
   endtask

   task automatic send(input logic [9:0] p, input logic jk, input logic dat, input logic [9:0] e);
      @(posedge sys_clk);
      tx_in_valid <= 1'b1;
      tx_in_pair <= p;
      tx_in_jk <= jk;
      tx_in_data <= dat;
      expq.push_back(e);
      acc();
   endtask

   task automatic cmp_out();
      k = 0;
      while (outq.size() < expq.size() && k < 80)
      begin
         @(posedge sys_clk);
         k++;
      end
      repeat (10) @(posedge sys_clk);
      `CHK("tx count", expq.size(), outq.size())
      foreach (expq[i])
         if (i < outq.size())
            `CHK("tx pair", expq[i], outq[i])
      outq.delete();
      expq.delete();
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      rst = 1'b1;
      cb_addr = 8'h00;
      cb_wr = 1'b0;
      cb_rd = 1'b0;
      cb_wdata = 8'h00;
      inj_mode = sil_pkg::MODE_NONE;
      injection_threshold = 8'h00;
      tx_in_valid = 1'b0;
      tx_in_pair = 10'h000;
      tx_in_jk = 1'b0;
      tx_in_data = 1'b0;
      tx_out_ready = 1'b1;
      rx_valid = 1'b0;
      rx_pair = 10'h000;
      signal_detect = 1'b1;
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      cb_rd <= 1'b1;
      cb_addr <= sil_pkg::ADDR_LINE;
      @(posedge sys_clk);
      cb_rd <= 1'b0;
      @(posedge sys_clk);
      `CHK("line state at reset", 8'h08, cb_rdata)
      rd(sil_pkg::ADDR_FIRST, v);
      `CHK("first symbol reset", 8'hE0, v)
      rd(sil_pkg::ADDR_SECOND, v);
      `CHK("second symbol reset", 8'hE0, v)
      // write then read on the very next edge
      cb_wr <= 1'b1;
      cb_addr <= sil_pkg::ADDR_FIRST;
      cb_wdata <= 8'h1F;
      @(posedge sys_clk);
      cb_wr <= 1'b0;
      cb_rd <= 1'b1;
      @(posedge sys_clk);
      cb_rd <= 1'b0;
      @(posedge sys_clk);
      `CHK("first symbol", 8'h1F, cb_rdata)
      setsym();
      rd(sil_pkg::ADDR_FIRST, v);
      `CHK("first symbol", 8'hF5, v)
      rd(sil_pkg::ADDR_SECOND, v);
      `CHK("second symbol", 8'hEA, v)
      rd(sil_pkg::ADDR_LINE, keep);
      wr(sil_pkg::ADDR_LINE, 8'hFF);
      @(posedge sys_clk);
      `CHK("write reject", 1'b1, cb_write_reject)
      @(posedge sys_clk);
      `CHK("reject end", 1'b0, cb_write_reject)
      rd(sil_pkg::ADDR_LINE, v);
      `CHK("line state kept", keep, v)
      rd(8'h09, v);
      `CHK("unmapped read", 8'h00, v)
      // line state recognition from the receive side
      rx_chk(JK, 1, 8'h00);
      rx_chk({sil_pkg::SYM_I, sil_pkg::SYM_I}, 2, 8'h01);
      rx_chk({sil_pkg::SYM_H, sil_pkg::SYM_H}, 8, 8'h05);
      rx_chk({sil_pkg::SYM_Q, sil_pkg::SYM_Q}, 8, 8'h06);
      rx_chk({sil_pkg::SYM_Q, sil_pkg::SYM_H}, 8, 8'h04);
      rx_chk({5'h0E, 5'h0E}, 16, 8'h07);
      signal_detect <= 1'b0;
      repeat (6) @(posedge sys_clk);
      rx_chk(JK, 0, 8'h02);
      signal_detect <= 1'b1;
      // pass-through, then continuous replacement of data only
      send(10'h1C3, 1'b0, 1'b1, 10'h1C3);
      inj_mode <= sil_pkg::MODE_CONT;
      send(10'h1C4, 1'b0, 1'b1, INJ);
      send(JK, 1'b1, 1'b0, JK);
      send(10'h1C5, 1'b0, 1'b1, INJ);
      cmp_out();
      // sink stalls: two pairs held, third refused until drained
      inj_mode <= sil_pkg::MODE_NONE;
      tx_out_ready <= 1'b0;
      send(10'h2A1, 1'b0, 1'b1, 10'h2A1);
      send(10'h2A2, 1'b0, 1'b1, 10'h2A2);
      @(posedge sys_clk);
      tx_in_valid <= 1'b1;
      tx_in_pair <= 10'h2A3;
      expq.push_back(10'h2A3);
      keep = 8'h00;
      repeat (24)
      begin
         @(posedge sys_clk);
         if (tx_in_ready === 1'b1)
            keep++;
      end
      `CHK("ready while full", 8'h00, keep)
      tx_out_ready <= 1'b1;
      acc();
      cmp_out();
      // periodic: n = 2 gives every third data pair, counter cleared by reset
      reset_dut(2);
      setsym();
      injection_threshold <= 8'h02;
      inj_mode <= sil_pkg::MODE_PERIODIC;
      for (int i = 1; i <= 6; i++)
         send(10'h1C0 + 10'(i), 1'b0, 1'b1, (i == 1 || i == 4) ? INJ : 10'h1C0 + 10'(i));
      cmp_out();
      // one shot: third pair after delimiter, once only until re-armed
      reset_dut(2);
      setsym();
      injection_threshold <= 8'h03;
      inj_mode <= sil_pkg::MODE_ONESHOT;
      repeat (2) @(posedge sys_clk);
      for (int r = 0; r < 2; r++)
      begin
         send(JK, 1'b1, 1'b0, JK);
         for (int i = 1; i <= 4; i++)
            send(10'h1C0 + 10'(i), 1'b0, 1'b1,
               (r == 0 && i == 3) ? INJ : 10'h1C0 + 10'(i));
      end
      cmp_out();
      `CHK("one shot pulses", 1, done_cnt)
      inj_mode <= sil_pkg::MODE_NONE;
      injection_threshold <= 8'h00;
      repeat (2) @(posedge sys_clk);
      inj_mode <= sil_pkg::MODE_ONESHOT;
      repeat (2) @(posedge sys_clk);
      send(JK, 1'b1, 1'b0, INJ);
      send(10'h1C1, 1'b0, 1'b1, 10'h1C1);
      cmp_out();
      `CHK("one shot pulses", 2, done_cnt)
      stop_test();
   end

   // whole run is under a thousand cycles; a hang is cut well beyond that
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      failures++;
      stop_test();
   end
endmodule
`default_nettype wire
